// [lmc_pkg.sv]
// Function
// - Matrix control bit 3 enables ghost prevention; reset value off.
// - Mode bits 2..1: 00 frame1, 01 frame2, 10 melody, 11 scroll.
// - Matrix control bit 0 switches matrix on; reset value off.
// - Normal and melody modes: frame select 0 writes frame 1, 1 writes frame 2.
// - Melody mode: frame select 1 writes frame 2 as per-LED melody enables.
// - Scroll mode writes go to the currently free frame, ignoring frame select.
// - Write-only frame bytes 06h..17h, bit 7 LED A8 down to bit 0 LED A1.
// - Outside scroll mode, frame data lands in frame 1 when select is 0, frame 2 when 1.
// - Melody mode displays frame 1; frame 2 gates melody per LED.
// - Threshold register one-hot, bit n selects level n+1; zero selects auto.
// - With several threshold bits set, only the first set bit counts.
// - Melody compensation bits 6..4 add 12.5% duty per code in melody mode.
// - Melody bits 0..3 enable bar-meter groups 1..4 during melody mode.
// - Oscillator runs whenever matrix is on, even with oscillator enable low.
package lmc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_MATRIX_CONTROL   = 6'h04;
    localparam logic [5:0] IDX_FRAME_SELECT     = 6'h05;
    localparam logic [5:0] IDX_FRAME_FIRST      = 6'h06;
    localparam logic [5:0] IDX_FRAME_LAST       = 6'h17;
    localparam logic [5:0] IDX_THRESHOLD        = 6'h18;
    localparam logic [5:0] IDX_MELODY_CONTROL   = 6'h19;
    localparam logic [5:0] IDX_OSC_CONTROL      = 6'h20;
    localparam logic [5:0] IDX_STATUS           = 6'h21;

    localparam int         FRAME_BYTES          = 18;
    localparam int         LED_COUNT            = 144;

    // Field positions
    localparam int         POS_MATRIX_ON        = 0;
    localparam int         POS_MODE_LO          = 1;
    localparam int         POS_GHOST            = 3;
    localparam int         POS_FRAME_SEL        = 0;
    localparam int         POS_COMP_LO          = 4;
    localparam int         POS_OSC_ENABLE       = 0;

    // Reset values
    localparam logic [7:0] RST_MATRIX_CONTROL   = 8'h00;
    localparam logic [7:0] RST_FRAME_SELECT     = 8'h00;
    localparam logic [7:0] RST_FRAME_DATA       = 8'h00;
    localparam logic [7:0] RST_THRESHOLD        = 8'h00;
    localparam logic [7:0] RST_MELODY_CONTROL   = 8'h00;
    localparam logic [7:0] RST_OSC_CONTROL      = 8'h00;

    // Matrix operating modes
    localparam logic [1:0] MODE_FRAME1          = 2'h0;
    localparam logic [1:0] MODE_FRAME2          = 2'h1;
    localparam logic [1:0] MODE_MELODY          = 2'h2;
    localparam logic [1:0] MODE_SCROLL          = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY            = 2'h0;
    localparam logic [1:0] RESP_SLVERR          = 2'h2;

    typedef struct packed {
        logic       matrix_on;
        logic       ghost_prevent_enable;
        logic [1:0] matrix_op_mode;
        logic       osc_run;
        logic       thresh_auto;
        logic [3:0] thresh_level;
        logic [2:0] melody_duty_comp;
        logic [3:0] bar_group_enable;
    } lmc_ctrl_t;

endpackage : lmc_pkg

// [lmc_top.sv]
module lmc_top #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                         CLK_SYS_I,
    input  wire logic                         RST_N_I,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]            S_AXI_AWADDR_I,
    input  wire logic [2:0]                   S_AXI_AWPROT_I,
    input  wire logic                         S_AXI_AWVALID_I,
    output logic                              S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input  wire logic [31:0]                  S_AXI_WDATA_I,
    input  wire logic [3:0]                   S_AXI_WSTRB_I,
    input  wire logic                         S_AXI_WVALID_I,
    output logic                              S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]                        S_AXI_BRESP_O,
    output logic                              S_AXI_BVALID_O,
    input  wire logic                         S_AXI_BREADY_I,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]            S_AXI_ARADDR_I,
    input  wire logic [2:0]                   S_AXI_ARPROT_I,
    input  wire logic                         S_AXI_ARVALID_I,
    output logic                              S_AXI_ARREADY_O,
    // AXI4-Lite read data
    output logic [31:0]                       S_AXI_RDATA_O,
    output logic [1:0]                        S_AXI_RRESP_O,
    output logic                              S_AXI_RVALID_O,
    input  wire logic                         S_AXI_RREADY_I,
    // Scroll engine
    input  wire logic                         SCROLL_ADVANCE_I,
    // Matrix outputs
    output lmc_pkg::lmc_ctrl_t                CTRL_O,
    output logic [lmc_pkg::LED_COUNT-1:0]     DISPLAY_O,
    output logic [lmc_pkg::LED_COUNT-1:0]     MELODY_LED_EN_O
);

    localparam int NB = lmc_pkg::FRAME_BYTES;

    // Register storage
    logic [7:0]             matrix_control_ff;
    logic                   frame_write_select_ff;
    logic [7:0]             threshold_onehot_ff;
    logic [7:0]             melody_control_ff;
    logic                   osc_enable_ff;
    logic [NB-1:0][7:0]     frame1_ff;
    logic [NB-1:0][7:0]     frame2_ff;
    logic                   scroll_show_ff;

    // Bus state
    logic                   aw_rdy_ff;
    logic                   w_rdy_ff;
    logic                   aw_got_ff;
    logic                   w_got_ff;
    logic [5:0]             aw_idx_ff;
    logic                   aw_bad_ff;
    logic [7:0]             wdata_ff;
    logic                   wlane_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   ar_rdy_ff;
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;

    // Output registers
    lmc_pkg::lmc_ctrl_t                 ctrl_ff;
    logic [lmc_pkg::LED_COUNT-1:0]      display_ff;
    logic [lmc_pkg::LED_COUNT-1:0]      melody_en_ff;

    // Decoded fields
    logic                   matrix_on;
    logic [1:0]             matrix_op_mode;
    logic                   ghost_prevent_enable;
    logic                   do_write;
    logic                   wr_en;
    logic                   frame_hit;
    logic [5:0]             frame_off;
    logic                   write_frame2;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic [5:0]             ar_idx;
    logic                   ar_bad;
    logic [3:0]             nxt_thresh_level;
    logic [7:0]             status_byte;
    logic [7:0]             nxt_rbyte;
    logic                   nxt_rerr;

    assign matrix_on            = matrix_control_ff[lmc_pkg::POS_MATRIX_ON];
    assign matrix_op_mode       = matrix_control_ff[lmc_pkg::POS_MODE_LO +: 2];
    assign ghost_prevent_enable = matrix_control_ff[lmc_pkg::POS_GHOST];

    // Handshakes; a write lands only with lane 0 strobed and a mapped address
    assign aw_take  = S_AXI_AWVALID_I && aw_rdy_ff;
    assign w_take   = S_AXI_WVALID_I && w_rdy_ff;
    assign ar_take  = S_AXI_ARVALID_I && ar_rdy_ff;
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_en    = do_write && wlane_ff && !aw_bad_ff;

    assign frame_hit = (aw_idx_ff >= lmc_pkg::IDX_FRAME_FIRST) && (aw_idx_ff <= lmc_pkg::IDX_FRAME_LAST);
    assign frame_off = aw_idx_ff - lmc_pkg::IDX_FRAME_FIRST;

    // Scroll mode picks the free frame; otherwise the select bit steers
    assign write_frame2 = (matrix_op_mode == lmc_pkg::MODE_SCROLL) ? !scroll_show_ff
                                                                   : frame_write_select_ff;

    assign ar_idx = S_AXI_ARADDR_I[7:2];
    assign ar_bad = (S_AXI_ARADDR_I[ADDR_W-1:8] != '0);

    // Write address channel
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_rdy_ff <= 1'b1;
            aw_got_ff <= 1'b0;
            aw_idx_ff <= 6'h00;
            aw_bad_ff <= 1'b0;
        end else if (aw_take) begin
            aw_rdy_ff <= 1'b0;
            aw_got_ff <= 1'b1;
            aw_idx_ff <= S_AXI_AWADDR_I[7:2];
            aw_bad_ff <= (S_AXI_AWADDR_I[ADDR_W-1:8] != '0);
        end else if (do_write) begin
            aw_got_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY_I) begin
            aw_rdy_ff <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            w_rdy_ff <= 1'b1;
            w_got_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (w_take) begin
            w_rdy_ff <= 1'b0;
            w_got_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA_I[7:0];
            wlane_ff <= S_AXI_WSTRB_I[0];
        end else if (do_write) begin
            w_got_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY_I) begin
            w_rdy_ff <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= lmc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= aw_bad_ff ? lmc_pkg::RESP_SLVERR : lmc_pkg::RESP_OKAY;
            case (aw_idx_ff)
                lmc_pkg::IDX_MATRIX_CONTROL,
                lmc_pkg::IDX_FRAME_SELECT,
                lmc_pkg::IDX_THRESHOLD,
                lmc_pkg::IDX_MELODY_CONTROL,
                lmc_pkg::IDX_OSC_CONTROL,
                lmc_pkg::IDX_STATUS: begin
                end
                default: begin
                    if (!frame_hit) begin
                        bresp_ff <= lmc_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end else if (S_AXI_BREADY_I) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Control registers; unused bits stored as zero
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            matrix_control_ff     <= lmc_pkg::RST_MATRIX_CONTROL;
            frame_write_select_ff <= lmc_pkg::RST_FRAME_SELECT[lmc_pkg::POS_FRAME_SEL];
            threshold_onehot_ff   <= lmc_pkg::RST_THRESHOLD;
            melody_control_ff     <= lmc_pkg::RST_MELODY_CONTROL;
            osc_enable_ff         <= lmc_pkg::RST_OSC_CONTROL[lmc_pkg::POS_OSC_ENABLE];
        end else if (wr_en) begin
            case (aw_idx_ff)
                lmc_pkg::IDX_MATRIX_CONTROL: matrix_control_ff     <= {4'h0, wdata_ff[3:0]};
                lmc_pkg::IDX_FRAME_SELECT:   frame_write_select_ff <= wdata_ff[lmc_pkg::POS_FRAME_SEL];
                lmc_pkg::IDX_THRESHOLD:      threshold_onehot_ff   <= wdata_ff;
                lmc_pkg::IDX_MELODY_CONTROL: melody_control_ff     <= {1'b0, wdata_ff[6:0]};
                lmc_pkg::IDX_OSC_CONTROL:    osc_enable_ff         <= wdata_ff[lmc_pkg::POS_OSC_ENABLE];
                default: begin
                end
            endcase
        end
    end

    // Frame storage, one byte per register
    generate
        for (genvar i = 0; i < NB; i++) begin : g_frame
            always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    frame1_ff[i] <= lmc_pkg::RST_FRAME_DATA;
                    frame2_ff[i] <= lmc_pkg::RST_FRAME_DATA;
                end else if (wr_en && frame_hit && (frame_off == 6'(i))) begin
                    if (write_frame2) begin
                        frame2_ff[i] <= wdata_ff;
                    end else begin
                        frame1_ff[i] <= wdata_ff;
                    end
                end
            end
        end
    endgenerate

    // Frame shown during scroll; the other one is free for writes
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scroll_show_ff <= 1'b0;
        end else if (SCROLL_ADVANCE_I && matrix_on && (matrix_op_mode == lmc_pkg::MODE_SCROLL)) begin
            scroll_show_ff <= !scroll_show_ff;
        end
    end

    // First set threshold bit wins, lowest index first
    always_comb begin
        nxt_thresh_level = 4'h0;
        for (int n = 7; n >= 0; n--) begin
            if (threshold_onehot_ff[n]) begin
                nxt_thresh_level = 4'(n + 1);
            end
        end
    end

    assign status_byte = {nxt_thresh_level, 2'h0, ctrl_ff.osc_run, scroll_show_ff};

    // Read data mux
    always_comb begin
        nxt_rbyte = 8'h00;
        nxt_rerr  = ar_bad;
        case (ar_idx)
            lmc_pkg::IDX_MATRIX_CONTROL: nxt_rbyte = matrix_control_ff;
            lmc_pkg::IDX_FRAME_SELECT:   nxt_rbyte = {7'h00, frame_write_select_ff};
            lmc_pkg::IDX_THRESHOLD:      nxt_rbyte = threshold_onehot_ff;
            lmc_pkg::IDX_MELODY_CONTROL: nxt_rbyte = melody_control_ff;
            lmc_pkg::IDX_OSC_CONTROL:    nxt_rbyte = {7'h00, osc_enable_ff};
            lmc_pkg::IDX_STATUS:         nxt_rbyte = status_byte;
            default: begin
                if (!((ar_idx >= lmc_pkg::IDX_FRAME_FIRST) && (ar_idx <= lmc_pkg::IDX_FRAME_LAST))) begin
                    nxt_rerr = 1'b1;
                end
            end
        endcase
        if (nxt_rerr) begin
            nxt_rbyte = 8'h00;
        end
    end

    // Read channel
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ar_rdy_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= lmc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            ar_rdy_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h00_0000, nxt_rbyte};
            rresp_ff  <= nxt_rerr ? lmc_pkg::RESP_SLVERR : lmc_pkg::RESP_OKAY;
        end else if (rvalid_ff && S_AXI_RREADY_I) begin
            rvalid_ff <= 1'b0;
            ar_rdy_ff <= 1'b1;
        end
    end

    // Control outputs
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            // Reset view mirrors the register defaults
            ctrl_ff.matrix_on            <= lmc_pkg::RST_MATRIX_CONTROL[lmc_pkg::POS_MATRIX_ON];
            ctrl_ff.ghost_prevent_enable <= lmc_pkg::RST_MATRIX_CONTROL[lmc_pkg::POS_GHOST];
            ctrl_ff.matrix_op_mode       <= lmc_pkg::RST_MATRIX_CONTROL[lmc_pkg::POS_MODE_LO +: 2];
            ctrl_ff.osc_run              <= lmc_pkg::RST_OSC_CONTROL[lmc_pkg::POS_OSC_ENABLE];
            ctrl_ff.thresh_auto          <= (lmc_pkg::RST_THRESHOLD == 8'h00);
            ctrl_ff.thresh_level         <= 4'h0;
            ctrl_ff.melody_duty_comp     <= 3'h0;
            ctrl_ff.bar_group_enable     <= 4'h0;
        end else begin
            ctrl_ff.matrix_on            <= matrix_on;
            ctrl_ff.ghost_prevent_enable <= ghost_prevent_enable;
            ctrl_ff.matrix_op_mode       <= matrix_op_mode;
            ctrl_ff.osc_run              <= osc_enable_ff || matrix_on;
            ctrl_ff.thresh_auto          <= (threshold_onehot_ff == 8'h00);
            ctrl_ff.thresh_level         <= nxt_thresh_level;
            if (matrix_op_mode == lmc_pkg::MODE_MELODY) begin
                ctrl_ff.melody_duty_comp <= melody_control_ff[lmc_pkg::POS_COMP_LO +: 3];
                ctrl_ff.bar_group_enable <= melody_control_ff[3:0];
            end else begin
                ctrl_ff.melody_duty_comp <= 3'h0;
                ctrl_ff.bar_group_enable <= 4'h0;
            end
        end
    end

    // Pixel outputs per mode
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            display_ff   <= '0;
            melody_en_ff <= '0;
        end else if (!matrix_on) begin
            display_ff   <= '0;
            melody_en_ff <= '0;
        end else begin
            melody_en_ff <= '0;
            case (matrix_op_mode)
                lmc_pkg::MODE_FRAME1: display_ff <= frame1_ff;
                lmc_pkg::MODE_FRAME2: display_ff <= frame2_ff;
                lmc_pkg::MODE_MELODY: begin
                    display_ff   <= frame1_ff;
                    melody_en_ff <= frame2_ff;
                end
                lmc_pkg::MODE_SCROLL: display_ff <= scroll_show_ff ? frame2_ff : frame1_ff;
                default:              display_ff <= frame1_ff;
            endcase
        end
    end

    assign S_AXI_AWREADY_O = aw_rdy_ff;
    assign S_AXI_WREADY_O  = w_rdy_ff;
    assign S_AXI_BVALID_O  = bvalid_ff;
    assign S_AXI_BRESP_O   = bresp_ff;
    assign S_AXI_ARREADY_O = ar_rdy_ff;
    assign S_AXI_RVALID_O  = rvalid_ff;
    assign S_AXI_RDATA_O   = rdata_ff;
    assign S_AXI_RRESP_O   = rresp_ff;
    assign CTRL_O          = ctrl_ff;
    assign DISPLAY_O       = display_ff;
    assign MELODY_LED_EN_O = melody_en_ff;

endmodule : lmc_top

// [lmc_top_props.sv]
module lmc_top_props (
    // Clock and reset
    input wire logic                          CLK_SYS_I,
    input wire logic                          RST_N_I,
    // Bus handshakes
    input wire logic                          S_AXI_AWVALID_I,
    input wire logic                          S_AXI_AWREADY_O,
    input wire logic                          S_AXI_WVALID_I,
    input wire logic                          S_AXI_WREADY_O,
    input wire logic [1:0]                    S_AXI_BRESP_O,
    input wire logic                          S_AXI_BVALID_O,
    input wire logic                          S_AXI_BREADY_I,
    input wire logic                          S_AXI_ARVALID_I,
    input wire logic                          S_AXI_ARREADY_O,
    input wire logic [31:0]                   S_AXI_RDATA_O,
    input wire logic                          S_AXI_RVALID_O,
    input wire logic                          S_AXI_RREADY_I,
    // Matrix outputs
    input wire lmc_pkg::lmc_ctrl_t            CTRL_O,
    input wire logic [lmc_pkg::LED_COUNT-1:0] DISPLAY_O,
    input wire logic [lmc_pkg::LED_COUNT-1:0] MELODY_LED_EN_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    a_write_answer: assert property ((S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O)
        |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O) else $error("write answer not two cycles after accept");
    a_read_answer: assert property ((S_AXI_ARVALID_I && S_AXI_ARREADY_O) |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read answer not one cycle after accept");
    a_b_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped early");
    a_r_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped early");
    a_busy_refuse: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write accepted while response pending");
    a_rdata_byte: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_osc_auto: assert property (CTRL_O.matrix_on |-> CTRL_O.osc_run)
        else $error("oscillator off while matrix on");
    a_matrix_blank: assert property (!CTRL_O.matrix_on |-> DISPLAY_O == '0)
        else $error("display lit while matrix off");
    a_melody_gate: assert property (CTRL_O.matrix_op_mode != lmc_pkg::MODE_MELODY |->
        MELODY_LED_EN_O == '0 && CTRL_O.melody_duty_comp == 3'h0 && CTRL_O.bar_group_enable == 4'h0)
        else $error("melody outputs active outside melody mode");
    a_thresh_auto: assert property (CTRL_O.thresh_auto == (CTRL_O.thresh_level == 4'h0))
        else $error("auto threshold flag disagrees with level");
    a_thresh_range: assert property (CTRL_O.thresh_level <= 4'h8)
        else $error("threshold level out of range");

    c_write: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
    c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
    c_scroll: cover property (CTRL_O.matrix_on && CTRL_O.matrix_op_mode == lmc_pkg::MODE_SCROLL);
    c_melody: cover property (MELODY_LED_EN_O != '0);
endmodule : lmc_top_props

bind lmc_top lmc_top_props u_props (.CLK_SYS_I, .RST_N_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I,
    .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
    .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .CTRL_O, .DISPLAY_O, .MELODY_LED_EN_O);

// [lmc_scroll_model.sv]
module lmc_scroll_model (
    // Clock
    input  wire logic clk_i,
    // Frame finished pulse
    output logic      advance_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial advance_o = 1'b0;
    // One-cycle pulse when a shown frame has scrolled out
    task automatic frame_done();
        @(posedge clk_i);
        advance_o <= 1'b1;
        @(posedge clk_i);
        advance_o <= 1'b0;
    endtask : frame_done
endmodule : lmc_scroll_model

// [lmc_top_tb.sv]
module lmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          clk = 1'b0, rst_n = 1'b0;
    logic [11:0]                   awaddr = '0, araddr = '0;
    logic                          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0]                   wdata = '0, rdata, d;
    logic                          awready, wready, bvalid, arready, rvalid, adv;
    logic [1:0]                    bresp, rresp, r;
    lmc_pkg::lmc_ctrl_t            ctrl;
    logic [lmc_pkg::LED_COUNT-1:0] disp, mel;
    int                            error_cnt = 0, samples_checked = 0;

    always #10 clk = ~clk;

    lmc_top uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .SCROLL_ADVANCE_I(adv), .CTRL_O(ctrl), .DISPLAY_O(disp), .MELODY_LED_EN_O(mel));
    lmc_scroll_model u_scroll (.clk_i(clk), .advance_o(adv));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_resp
    task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        rs = bresp;
        if (n >= 50) error_cnt++;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        dt = rdata;
        rs = rresp;
        if (n >= 50) error_cnt++;
    endtask : rd
    task automatic w(input logic [11:0] a, input logic [7:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
        chk_resp("bresp", lmc_pkg::RESP_OKAY, rs);
    endtask : w
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] dt;
        logic [1:0]  rs;
        rd(a, dt, rs);
        chk_resp("rresp", lmc_pkg::RESP_OKAY, rs);
        chk("rdata", e, dt);
    endtask : rchk
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask : settle
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #100us;
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rchk(12'h010, 0);
        rchk(12'h014, 0);
        rchk(12'h060, 0);
        rchk(12'h064, 0);
        chk("ctrl", 32'h0000_0800, ctrl);
        $display("test reset finished");
        for (int m = 0; m < 4; m++) begin
            w(12'h010, 8'(m * 2 + 9));
            rchk(12'h010, 32'(m * 2 + 9));
            settle();
            chk("mode", m, ctrl.matrix_op_mode);
            chk("ghost", 1, ctrl.ghost_prevent_enable);
            chk("osc", 1, ctrl.osc_run);
        end
        w(12'h010, 8'h00);
        settle();
        chk("on", 0, ctrl.matrix_on);
        chk("osc", 0, ctrl.osc_run);
        $display("test control finished");
        w(12'h010, 8'h01);
        w(12'h018, 8'ha5);
        w(12'h05c, 8'h3c);
        settle();
        chk("disp0", 8'ha5, disp[7:0]);
        chk("disp17", 8'h3c, disp[143:136]);
        rchk(12'h018, 0);
        w(12'h014, 8'h01);
        w(12'h018, 8'h5a);
        settle();
        chk("disp0", 8'ha5, disp[7:0]);
        w(12'h010, 8'h03);
        settle();
        chk("disp0", 8'h5a, disp[7:0]);
        $display("test frames finished");
        w(12'h064, 8'h7f);
        w(12'h010, 8'h05);
        settle();
        chk("disp0", 8'ha5, disp[7:0]);
        chk("mel0", 8'h5a, mel[7:0]);
        chk("comp", 7, ctrl.melody_duty_comp);
        chk("groups", 4'hf, ctrl.bar_group_enable);
        w(12'h018, 8'h81);
        settle();
        chk("mel0", 8'h81, mel[7:0]);
        chk("disp0", 8'ha5, disp[7:0]);
        w(12'h014, 8'h00);
        w(12'h010, 8'h01);
        settle();
        chk("comp", 0, ctrl.melody_duty_comp);
        chk("mel0", 0, mel[7:0]);
        w(12'h010, 8'h00);
        settle();
        chk("disp", 0, disp[31:0]);
        $display("test melody finished");
        w(12'h014, 8'h01);
        w(12'h010, 8'h07);
        w(12'h018, 8'h11);
        settle();
        chk("disp0", 8'ha5, disp[7:0]);
        u_scroll.frame_done();
        settle();
        chk("disp0", 8'h11, disp[7:0]);
        w(12'h018, 8'h22);
        u_scroll.frame_done();
        settle();
        chk("disp0", 8'h22, disp[7:0]);
        $display("test scroll finished");
        for (int n = 0; n < 8; n++) begin
            w(12'h060, 8'(1 << n));
            settle();
            chk("level", n + 1, ctrl.thresh_level);
            chk("auto", 0, ctrl.thresh_auto);
        end
        w(12'h060, 8'h0c);
        settle();
        chk("level", 3, ctrl.thresh_level);
        w(12'h060, 8'h00);
        settle();
        chk("auto", 1, ctrl.thresh_auto);
        $display("test threshold finished");
        wr(12'h068, 8'hff, r);
        chk_resp("bresp", lmc_pkg::RESP_SLVERR, r);
        rd(12'h068, d, r);
        chk_resp("rresp", lmc_pkg::RESP_SLVERR, r);
        chk("rdata", 0, d);
        wr(12'h110, 8'h00, r);
        chk_resp("bresp", lmc_pkg::RESP_SLVERR, r);
        rchk(12'h010, 8'h07);
        $display("test unmapped finished");
        w(12'h010, 8'h00);
        w(12'h080, 8'h01);
        rchk(12'h080, 8'h01);
        settle();
        chk("osc", 1, ctrl.osc_run);
        rchk(12'h084, 8'h02);
        w(12'h080, 8'h00);
        $display("test oscillator finished");
        end_of_test();
    end
endmodule : lmc_top_tb
